// ==== src/nvm_command_controller.sv ====
// Register front end of the nonvolatile memory controller.
// Assumes the CPU side flags key writes, instruction retires and
// page-buffer stores as one-cycle pulses on mclk.
//
// Overview of operation
// - Unkeyed write to guarded register ignored
// - Each key opens only its own register
// - Codes 1..3 program, erase, erase-program page
// - Codes 4..6 wipe buffer, whole, EEPROM erase
// - Code 0 none; fuse code debug-port only
// - Locked boot area reads and fetches zero
// - Boot lock written from boot only, sticky
// - Boot lock acts after leaving boot area
// - App write guard set-only, blocks app page commands
// - Fault bit reports last operation's error
// - Status busy bits for EEPROM and flash
// - Enabled idle flag gives level interrupt
// - Idle flag held while EEPROM idle, W1C
// - Data register feeds fuse programming
// - Address register tracks last updated location
// - Erase needs loaded byte; buffer self-clears
// - Buffer wipe sets ones, halts seven cycles
// - EEPROM page ops touch loaded bytes only
//
// Chosen here: the strobed register port.
`default_nettype none
module nvm_command_controller (
    input  wire logic        mclk,          // 10 MHz clock
    input  wire logic        srst,          // Synchronous reset
    input  wire logic [3:0]  regAddr,       // Register offset
    input  wire logic [7:0]  regWdata,      // Write data
    input  wire logic        regWrite,      // Write strobe
    input  wire logic        regRead,       // Read strobe
    output logic      [7:0]  regRdata,      // Read data
    input  wire logic        keySpm,        // self_prog_key written
    input  wire logic        keyIoreg,      // io_register_key written
    input  wire logic        cpuInstr,      // Instruction retired
    input  wire logic        fromDebugPort, // Access from debug port
    input  wire logic        execInBoot,    // CPU runs in boot area
    input  wire logic        keepEepromFuse,// Keep EEPROM on whole erase
    input  wire logic        bufWrite,      // Page buffer store
    input  wire logic [15:0] bufAddr,       // Address of that store
    output logic             bootHide,      // Boot reads/fetches zero
    output logic             cpuHalt,       // Stall the CPU
    output logic             opStart,       // Operation begins
    output logic      [2:0]  opCode,        // Operation code
    output logic             opEeprom,      // Operation targets EEPROM
    output logic      [31:0] opByteMask,    // Loaded page bytes
    output logic             bufOnes,       // Set page buffer to ones
    output logic             fuseStrobe,    // Program fuse now
    output logic      [15:0] fuseValue,     // Value for the fuse
    output logic      [15:0] targetAddr,    // Target location
    output logic             irqEeIdle      // Level interrupt
);
    import nvm_cmd_pkg::*;

    typedef struct packed {
        logic [2:0]  cmd;      // Last accepted command
        logic        guard;    // app_area_write_guard
        logic        lockSet;  // boot_area_lock written
        logic        lockLive; // Boot lock in force
        logic        fault;    // write_fault
        logic        ieEn;     // Idle irq enable
        logic        idle;     // eeprom_idle_irq flag
        logic [15:0] data;     // fuse_write_value
        logic [15:0] addr;     // target_location
        logic [2:0]  spmWin;   // Instructions left, command key
        logic [2:0]  ioWin;    // Instructions left, lock key
        logic        loaded;   // Buffer holds a byte
        logic        mixed;    // Loads from two sections
        logic [1:0]  loadSec;  // Section of first load
        logic [31:0] mask;     // Loaded byte positions
        logic [2:0]  haltCnt;  // Wipe halt cycles left
        logic        eeAll;    // EEPROM erase halts CPU
        logic        fGo;      // Start flash timer
        logic        eGo;      // Start EEPROM timer
        logic [15:0] fLen;     // Flash op length
        logic [15:0] eLen;     // EEPROM op length
        logic [7:0]  rdata;    // Read data
        logic        opStart;  // Start pulse
        logic [2:0]  opCode;   // Started code
        logic        opEe;     // Started on EEPROM
        logic        ones;     // Buffer wipe pulse
        logic        fuseStb;  // Fuse pulse
        logic        irq;      // Interrupt level
        logic        halt;     // CPU stall level
    } state_type;

    state_type s_ff;   // Registered state
    state_type nxt_s;  // Next state

    logic flash_in_use;  // Flash timer running
    logic fDone;  // Flash op finished
    logic eBusy;  // EEPROM timer running
    logic eDone;  // EEPROM op finished

    // Section of an address
    function automatic logic [1:0] secOf(input logic [15:0] a);
        if (a >= EE_BASE && a < EE_END) begin
            secOf = SEC_EE;
        end else if (a >= APP_BASE) begin
            secOf = SEC_APP;
        end else if (a >= BOOT_BASE) begin
            secOf = SEC_BOOT;
        end else begin
            secOf = SEC_NONE;
        end
    endfunction : secOf

    // Array timers
    nvm_op_timer u_flash (
        .mclk (mclk),
        .srst (srst),
        .go   (s_ff.fGo),
        .len  (s_ff.fLen),
        .busy (flash_in_use),
        .done (fDone)
    );
    nvm_op_timer u_eeprom (
        .mclk (mclk),
        .srst (srst),
        .go   (s_ff.eGo),
        .len  (s_ff.eLen),
        .busy (eBusy),
        .done (eDone)
    );

    // Busy including a start already queued
    logic fNow;   // Flash busy seen by software
    logic eNow;   // EEPROM busy seen by software
    logic [1:0] tSec; // Section of target
    assign fNow = flash_in_use | s_ff.fGo;
    assign eNow = eBusy | s_ff.eGo;
    assign tSec = secOf(s_ff.addr);

    // All register, key and command behaviour
    always_comb begin
        nxt_s = s_ff;
        nxt_s.rdata = RST_BYTE;
        nxt_s.opStart = 1'b0;
        nxt_s.ones = 1'b0;
        nxt_s.fuseStb = 1'b0;
        nxt_s.fGo = 1'b0;
        nxt_s.eGo = 1'b0;
        // Key windows count retired instructions
        if (keySpm) begin
            nxt_s.spmWin = KEY_WINDOW;
        end else if (cpuInstr && s_ff.spmWin != 3'h0) begin
            nxt_s.spmWin = s_ff.spmWin - 3'h1;
        end
        if (keyIoreg) begin
            nxt_s.ioWin = KEY_WINDOW;
        end else if (cpuInstr && s_ff.ioWin != 3'h0) begin
            nxt_s.ioWin = s_ff.ioWin - 3'h1;
        end
        // Lock takes hold once code is outside boot
        if (s_ff.lockSet && !execInBoot) begin
            nxt_s.lockLive = 1'b1;
        end
        // Buffer empties after array operation
        if (fDone || eDone) begin
            nxt_s.loaded = 1'b0;
            nxt_s.mixed = 1'b0;
            nxt_s.mask = '0;
        end
        if (eDone) begin
            nxt_s.eeAll = 1'b0;
        end
        // Buffer stores track location and section
        if (bufWrite) begin
            nxt_s.mask[bufAddr[4:0]] = 1'b1;
            nxt_s.addr = bufAddr;
            if (!nxt_s.loaded) begin
                nxt_s.loadSec = secOf(bufAddr);
            end
            if (nxt_s.loaded && secOf(bufAddr) != s_ff.loadSec) begin
                nxt_s.mixed = 1'b1;
            end
            nxt_s.loaded = 1'b1;
        end
        if (s_ff.haltCnt != 3'h0) begin
            nxt_s.haltCnt = s_ff.haltCnt - 3'h1;
        end
        // Idle flag; hardware set beats software clear
        nxt_s.idle = !eBusy || (s_ff.idle && !(regWrite
            && regAddr == OFS_IFLAG && regWdata[BIT_IDLE]));
        // Register writes
        if (regWrite) begin
            unique case (regAddr)
                OFS_CMD: begin
                    // Only the self-programming key opens this
                    if (s_ff.spmWin != 3'h0) begin
                        nxt_s.spmWin = 3'h0;
                        nxt_s.cmd = regWdata[2:0];
                        nxt_s.fault = 1'b0;
                        unique case (regWdata[2:0])
                            CMD_PROG, CMD_ERASE, CMD_ERPRG: begin
                                if ((tSec == SEC_EE && eNow)
                                    || (tSec != SEC_EE && fNow)) begin
                                    nxt_s.fault = 1'b1;
                                end else if (s_ff.mixed
                                    || tSec == SEC_NONE
                                    || (tSec == SEC_APP && s_ff.guard)
                                    || (s_ff.loaded
                                    && s_ff.loadSec != tSec)) begin
                                    nxt_s.fault = 1'b1;
                                end else if (s_ff.loaded
                                    || regWdata[2:0] == CMD_PROG) begin
                                    // Erase idles with empty buffer
                                    nxt_s.opStart = 1'b1;
                                    nxt_s.opCode = regWdata[2:0];
                                    nxt_s.opEe = tSec == SEC_EE;
                                    nxt_s.eGo = tSec == SEC_EE;
                                    nxt_s.fGo = tSec != SEC_EE;
                                    nxt_s.eLen = LEN_PAGE;
                                    nxt_s.fLen = LEN_PAGE;
                                end
                            end
                            CMD_WIPE: begin
                                nxt_s.ones = 1'b1;
                                nxt_s.haltCnt = WIPE_CYCLES;
                                nxt_s.loaded = 1'b0;
                                nxt_s.mixed = 1'b0;
                                nxt_s.mask = '0;
                            end
                            CMD_WHOLE: begin
                                if (fNow || eNow) begin
                                    nxt_s.fault = 1'b1;
                                end else begin
                                    nxt_s.opStart = 1'b1;
                                    nxt_s.opCode = CMD_WHOLE;
                                    nxt_s.opEe = !keepEepromFuse;
                                    nxt_s.fGo = 1'b1;
                                    nxt_s.fLen = LEN_WHOLE;
                                    nxt_s.eGo = !keepEepromFuse;
                                    nxt_s.eLen = LEN_WHOLE;
                                end
                            end
                            CMD_EEALL: begin
                                if (eNow) begin
                                    nxt_s.fault = 1'b1;
                                end else begin
                                    nxt_s.opStart = 1'b1;
                                    nxt_s.opCode = CMD_EEALL;
                                    nxt_s.opEe = 1'b1;
                                    nxt_s.eGo = 1'b1;
                                    nxt_s.eLen = LEN_WHOLE;
                                    nxt_s.eeAll = 1'b1;
                                end
                            end
                            CMD_FUSE: begin
                                // CPU may never program fuses
                                if (!fromDebugPort || fNow) begin
                                    nxt_s.fault = 1'b1;
                                end else begin
                                    nxt_s.opStart = 1'b1;
                                    nxt_s.opCode = CMD_FUSE;
                                    nxt_s.opEe = 1'b0;
                                    nxt_s.fuseStb = 1'b1;
                                    nxt_s.fGo = 1'b1;
                                    nxt_s.fLen = LEN_FUSE;
                                end
                            end
                            default: begin
                                // No operation code
                            end
                        endcase
                    end
                end
                OFS_LOCK: begin
                    // Only the I/O key opens this; bits only set
                    if (s_ff.ioWin != 3'h0) begin
                        nxt_s.ioWin = 3'h0;
                        if (regWdata[BIT_GUARD]) begin
                            nxt_s.guard = 1'b1;
                        end
                        if (regWdata[BIT_BLOCK] && execInBoot) begin
                            nxt_s.lockSet = 1'b1;
                        end
                    end
                end
                OFS_IEN:   nxt_s.ieEn = regWdata[BIT_IDLE];
                OFS_DATAL: nxt_s.data[7:0] = regWdata;
                OFS_DATAH: nxt_s.data[15:8] = regWdata;
                OFS_ADDRL: nxt_s.addr[7:0] = regWdata;
                OFS_ADDRH: nxt_s.addr[15:8] = regWdata;
                default: begin
                    // Status and holes ignore writes; the idle flag clear is handled above
                end
            endcase
        end
        // Register reads, data in the next cycle
        if (regRead) begin
            unique case (regAddr)
                OFS_CMD:    nxt_s.rdata = {5'h00, s_ff.cmd};
                OFS_LOCK:   nxt_s.rdata = {6'h00, s_ff.lockSet,
                                           s_ff.guard};
                OFS_STATUS: nxt_s.rdata = {5'h00, s_ff.fault, eNow,
                                           fNow};
                OFS_IEN:    nxt_s.rdata = {7'h00, s_ff.ieEn};
                OFS_IFLAG:  nxt_s.rdata = {7'h00, s_ff.idle};
                OFS_DATAL:  nxt_s.rdata = s_ff.data[7:0];
                OFS_DATAH:  nxt_s.rdata = s_ff.data[15:8];
                OFS_ADDRL:  nxt_s.rdata = s_ff.addr[7:0];
                OFS_ADDRH:  nxt_s.rdata = s_ff.addr[15:8];
                default:    nxt_s.rdata = RST_BYTE;
            endcase
        end
        // Level outputs
        nxt_s.irq = nxt_s.ieEn && nxt_s.idle;
        nxt_s.halt = nxt_s.haltCnt != 3'h0
            || nxt_s.fGo || (flash_in_use && !fDone) || nxt_s.eeAll;
    end

    // State register
    always_ff @(posedge mclk) begin
        if (srst) begin
            s_ff <= '0;
        end else begin
            s_ff <= nxt_s;
        end
    end

    // Outputs straight from flops
    assign regRdata   = s_ff.rdata;
    assign bootHide   = s_ff.lockLive;
    assign cpuHalt    = s_ff.halt;
    assign opStart    = s_ff.opStart;
    assign opCode     = s_ff.opCode;
    assign opEeprom   = s_ff.opEe;
    assign opByteMask = s_ff.mask;
    assign bufOnes    = s_ff.ones;
    assign fuseStrobe = s_ff.fuseStb;
    assign fuseValue  = s_ff.data;
    assign targetAddr = s_ff.addr;
    assign irqEeIdle  = s_ff.irq;

    // Checks
    default clocking cb @(posedge mclk); endclocking
    default disable iff (srst);

    AST_UNKEYED_CMD: assert property (
        regWrite && regAddr == OFS_CMD && s_ff.spmWin == 3'h0
        |=> s_ff.cmd == $past(s_ff.cmd) && !s_ff.opStart)
        else $error("unkeyed command write took effect");
    AST_IO_KEY_ONLY: assert property (
        regWrite && regAddr == OFS_LOCK && s_ff.ioWin == 3'h0
        |=> s_ff.guard == $past(s_ff.guard))
        else $error("lock register changed without its key");
    AST_FUSE_PORT: assert property (
        s_ff.fuseStb |-> $past(fromDebugPort))
        else $error("fuse program started from the CPU");
    AST_WIPE_HALT: assert property (
        regWrite && regAddr == OFS_CMD && s_ff.spmWin != 3'h0
        && regWdata[2:0] == CMD_WIPE |=> cpuHalt [*7])
        else $error("buffer wipe halt shorter than seven cycles");
    AST_GUARD_STICKY: assert property (
        s_ff.guard |=> s_ff.guard)
        else $error("application guard cleared without reset");
    AST_IDLE_HELD: assert property (
        !eBusy |=> irqEeIdle == s_ff.ieEn && s_ff.idle)
        else $error("idle flag not held while EEPROM idle");
    AST_LOCK_DEFER: assert property (
        s_ff.lockLive && !$past(s_ff.lockLive) |-> !$past(execInBoot))
        else $error("boot lock acted while still in boot area");
    AST_STATUS_BUSY: assert property (
        regRead && regAddr == OFS_STATUS
        |=> regRdata[BIT_FLASH_IN_USE] == $past(fNow)
        && regRdata[BIT_EBUSY] == $past(eNow))
        else $error("status busy bits wrong");
endmodule : nvm_command_controller
`default_nettype wire

// ==== pkg/nvm_cmd_pkg.sv ====
// Constants shared by the nonvolatile command controller files.
// Assumes an 8-bit register port with byte offsets 0x0 to 0x9.
`default_nettype none
package nvm_cmd_pkg;
    // Register byte offsets
    localparam logic [3:0] OFS_CMD    = 4'h0;
    localparam logic [3:0] OFS_LOCK   = 4'h1;
    localparam logic [3:0] OFS_STATUS = 4'h2;
    localparam logic [3:0] OFS_IEN    = 4'h3;
    localparam logic [3:0] OFS_IFLAG  = 4'h4;
    localparam logic [3:0] OFS_DATAL  = 4'h6;
    localparam logic [3:0] OFS_DATAH  = 4'h7;
    localparam logic [3:0] OFS_ADDRL  = 4'h8;
    localparam logic [3:0] OFS_ADDRH  = 4'h9;
    // Field positions
    localparam int BIT_GUARD  = 0;
    localparam int BIT_BLOCK  = 1;
    localparam int BIT_FLASH_IN_USE  = 0;
    localparam int BIT_EBUSY  = 1;
    localparam int BIT_FAULT  = 2;
    localparam int BIT_IDLE   = 0;
    // Reset values
    localparam logic [7:0]  RST_BYTE = 8'h00;
    localparam logic [15:0] RST_WORD = 16'h0000;
    // Command codes
    localparam logic [2:0] CMD_NONE  = 3'h0;
    localparam logic [2:0] CMD_PROG  = 3'h1;
    localparam logic [2:0] CMD_ERASE = 3'h2;
    localparam logic [2:0] CMD_ERPRG = 3'h3;
    localparam logic [2:0] CMD_WIPE  = 3'h4;
    localparam logic [2:0] CMD_WHOLE = 3'h5;
    localparam logic [2:0] CMD_EEALL = 3'h6;
    localparam logic [2:0] CMD_FUSE  = 3'h7;
    // Memory sections
    localparam logic [1:0] SEC_BOOT  = 2'h0;
    localparam logic [1:0] SEC_APP   = 2'h1;
    localparam logic [1:0] SEC_EE    = 2'h2;
    localparam logic [1:0] SEC_NONE  = 2'h3;
    localparam logic [15:0] EE_BASE   = 16'h1400;
    localparam logic [15:0] EE_END    = 16'h1500;
    localparam logic [15:0] BOOT_BASE = 16'h8000;
    localparam logic [15:0] APP_BASE  = 16'h8200;
    // Instructions a key stays open, buffer-wipe halt cycles
    localparam logic [2:0] KEY_WINDOW  = 3'h4;
    localparam logic [2:0] WIPE_CYCLES = 3'h7;
    // Operation lengths in mclk cycles
    localparam logic [15:0] LEN_PAGE  = 16'h0028;
    localparam logic [15:0] LEN_WHOLE = 16'h00c8;
    localparam logic [15:0] LEN_FUSE  = 16'h0010;
endpackage : nvm_cmd_pkg
`default_nettype wire

// ==== src/nvm_op_timer.sv ====
// Busy timer for one memory array operation.
// Assumes go is a one-cycle pulse issued only while idle.
`default_nettype none
module nvm_op_timer (
    input  wire logic        mclk,
    input  wire logic        srst,
    input  wire logic        go,
    input  wire logic [15:0] len,
    output logic             busy,
    output logic             done
);
    import nvm_cmd_pkg::*;

    typedef struct packed {
        logic [15:0] cnt;   // Cycles left
        logic        busy;  // Operation running
        logic        done;  // End pulse
    } tmr_type;

    tmr_type s_ff;   // Registered state
    tmr_type nxt_s;  // Next state

    // Load on go, count down, pulse at the end
    always_comb begin
        nxt_s = s_ff;
        nxt_s.done = 1'b0;
        if (go) begin
            nxt_s.cnt = len;
            nxt_s.busy = 1'b1;
        end else if (s_ff.busy) begin
            if (s_ff.cnt <= 16'h0001) begin
                nxt_s.busy = 1'b0;
                nxt_s.done = 1'b1;
            end else begin
                nxt_s.cnt = s_ff.cnt - 16'h0001;
            end
        end
    end

    // State register
    always_ff @(posedge mclk) begin
        if (srst) begin
            s_ff <= '0;
        end else begin
            s_ff <= nxt_s;
        end
    end

    assign busy = s_ff.busy;
    assign done = s_ff.done;
endmodule : nvm_op_timer
`default_nettype wire

// ==== tb/test_nvm_command_controller.sv ====
// Self-checking bench for the nonvolatile command controller.
// Assumes the register port and key pulses described in the hand-over.
`default_nettype none
module test_nvm_command_controller;
    timeunit 1ns;
    timeprecision 100ps;
    import nvm_cmd_pkg::*;
    logic        mclk, srst, regWrite, regRead, keySpm, keyIoreg, cpuInstr;
    logic        fromDebugPort, execInBoot, keepEepromFuse, bufWrite;
    logic        bootHide, cpuHalt, opStart, opEeprom, bufOnes, fuseStrobe;
    logic        irqEeIdle;
    logic [3:0]  regAddr;
    logic [7:0]  regWdata, regRdata;
    logic [15:0] bufAddr, fuseValue, targetAddr;
    logic [2:0]  opCode;
    logic [31:0] opByteMask;
    int          n_fail, cmp_count, n;
    // Offsets read back as zero after reset, two unmapped
    logic [3:0] n_fail_tab [9] = '{OFS_CMD, OFS_LOCK, OFS_STATUS, OFS_IEN,
        4'h5, OFS_DATAL, OFS_DATAH, OFS_ADDRH, 4'ha};
    // Device under test
    nvm_command_controller dut_u (.mclk, .srst, .regAddr, .regWdata,
        .regWrite, .regRead, .regRdata, .keySpm, .keyIoreg, .cpuInstr,
        .fromDebugPort, .execInBoot, .keepEepromFuse, .bufWrite, .bufAddr,
        .bootHide, .cpuHalt, .opStart, .opCode, .opEeprom, .opByteMask,
        .bufOnes, .fuseStrobe, .fuseValue, .targetAddr, .irqEeIdle);
    // 10 MHz clock
    initial begin
        mclk = 0;
        forever #50 mclk = ~mclk;
    end
    // Compare and count
    task chk(input logic [31:0] got, input logic [31:0] exp, input string m);
        cmp_count++;
        if (got !== exp) begin
            n_fail++;
            $display("[FAIL] %0t %s got %h exp %h", $time, m, got, exp);
        end
    endtask : chk
    // One-cycle register write, keys dropped
    task wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge mclk);
        {keySpm, keyIoreg, cpuInstr} <= 3'h0;
        regAddr <= a; regWdata <= d; regWrite <= 1'b1;
        @(posedge mclk);
        regWrite <= 1'b0;
    endtask : wr
    // Key pulse, some retired instructions, then the write
    task kw(input logic s, input int ni, input logic [3:0] a,
            input logic [7:0] d);
        @(posedge mclk);
        keySpm <= s; keyIoreg <= ~s;
        repeat (ni) begin
            @(posedge mclk);
            {keySpm, keyIoreg} <= 2'h0; cpuInstr <= 1'b1;
        end
        wr(a, d);
    endtask : kw
    // Read strobe, data checked in the following cycle
    task rd(input logic [3:0] a, input logic [7:0] e, input string m);
        @(posedge mclk);
        regAddr <= a; regRead <= 1'b1;
        @(posedge mclk);
        regRead <= 1'b0;
        @(negedge mclk);
        chk(regRdata, e, m);
    endtask : rd
    // Counts, verdict, end of run
    task summarize;
        $display("checks %0d mismatches %0d", cmp_count, n_fail);
        if (n_fail == 0 && cmp_count > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask : summarize
    // Hang guard
    initial begin
        repeat (5000) @(posedge mclk);
        n_fail++;
        summarize();
    end
    // Test sequence
    initial begin
        {srst, regWrite, regRead, keySpm, keyIoreg, cpuInstr} = 6'h20;
        {fromDebugPort, execInBoot, keepEepromFuse, bufWrite} = 4'h0;
        regAddr = 4'h0; regWdata = 8'h00; bufAddr = 16'h0000;
        repeat (6) @(posedge mclk);
        srst <= 1'b0;
        foreach (n_fail_tab[i]) rd(n_fail_tab[i], RST_BYTE, "reset");
        rd(OFS_IFLAG, 8'h01, "idle flag");
        $display("reset values done");
        wr(OFS_CMD, 8'h04); rd(OFS_CMD, 8'h00, "unkeyed");
        kw(0, 0, OFS_CMD, 8'h04); rd(OFS_CMD, 8'h00, "wrong key");
        kw(1, 4, OFS_CMD, 8'h04); rd(OFS_CMD, 8'h00, "late");
        kw(1, 0, OFS_LOCK, 8'h01); rd(OFS_LOCK, 8'h00, "spm lock");
        kw(0, 3, OFS_LOCK, 8'h03); rd(OFS_LOCK, 8'h01, "guard");
        kw(0, 0, OFS_LOCK, 8'h00); rd(OFS_LOCK, 8'h01, "sticky");
        $display("protection done");
        kw(1, 0, OFS_CMD, {5'h0, CMD_WIPE});
        @(negedge mclk);
        chk(bufOnes, 1, "ones");
        n = 0;
        while (cpuHalt === 1'b1 && n < 20) begin
            n++;
            @(negedge mclk);
        end
        chk(n, 7, "halt");
        rd(OFS_CMD, 8'h04, "cmd back");
        $display("wipe done");
        @(posedge mclk) execInBoot <= 1'b1;
        kw(0, 0, OFS_LOCK, 8'h02); rd(OFS_LOCK, 8'h03, "lock");
        chk(bootHide, 0, "early");
        @(posedge mclk) execInBoot <= 1'b0;
        repeat (2) @(negedge mclk);
        chk(bootHide, 1, "hide");
        kw(0, 0, OFS_LOCK, 8'h00); rd(OFS_LOCK, 8'h03, "kept");
        $display("boot lock done");
        wr(OFS_DATAL, 8'h5a); wr(OFS_DATAH, 8'ha5);
        wr(OFS_ADDRL, 8'h34); wr(OFS_ADDRH, 8'h12);
        rd(OFS_DATAH, 8'ha5, "data"); rd(OFS_ADDRL, 8'h34, "addr");
        chk(fuseValue, 16'ha55a, "fv"); chk(targetAddr, 16'h1234, "ta");
        kw(1, 0, OFS_CMD, {5'h0, CMD_FUSE});
        @(negedge mclk) chk(fuseStrobe, 0, "cpu fuse");
        rd(OFS_STATUS, 8'h04, "fault");
        @(posedge mclk) fromDebugPort <= 1'b1;
        kw(1, 0, OFS_CMD, {5'h0, CMD_FUSE});
        @(negedge mclk) chk(fuseStrobe, 1, "dbg fuse");
        @(posedge mclk) fromDebugPort <= 1'b0;
        repeat (30) @(posedge mclk);
        rd(OFS_STATUS, 8'h00, "clear");
        $display("fuse done");
        @(posedge mclk) {bufWrite, bufAddr} <= {1'b1, 16'h1403};
        @(posedge mclk) bufWrite <= 1'b0;
        kw(1, 0, OFS_CMD, {5'h0, CMD_PROG});
        @(negedge mclk) chk({opStart, opEeprom, opCode}, 5'h19, "op");
        chk(opByteMask, 32'h8, "mask"); chk(targetAddr, 16'h1403, "t");
        rd(OFS_STATUS, 8'h02, "ee busy");
        wr(OFS_IFLAG, 8'h01); rd(OFS_IFLAG, 8'h00, "w1c");
        wr(OFS_IEN, 8'h01);
        @(negedge mclk) chk(irqEeIdle, 0, "no irq");
        repeat (50) @(posedge mclk);
        @(negedge mclk) chk(irqEeIdle, 1, "irq");
        rd(OFS_STATUS, 8'h00, "idle"); rd(OFS_IFLAG, 8'h01, "flag");
        chk(opByteMask, 32'h0, "buffer cleared");
        wr(OFS_IEN, 8'h00);
        repeat (2) @(negedge mclk);
        chk(irqEeIdle, 0, "irq off");
        $display("eeprom page done");
        // Whole EEPROM erase, then a command while it runs
        kw(1, 0, OFS_CMD, {5'h0, CMD_EEALL});
        @(negedge mclk);
        chk({opStart, opEeprom, opCode}, 5'h1e, "ee all");
        kw(1, 0, OFS_CMD, {5'h0, CMD_EEALL});
        @(negedge mclk) chk(opStart, 0, "busy cmd");
        rd(OFS_STATUS, 8'h06, "rejected");
        chk(cpuHalt, 1, "ee halt");
        repeat (210) @(posedge mclk);
        // Whole erase that spares the EEPROM
        @(posedge mclk) keepEepromFuse <= 1'b1;
        kw(1, 0, OFS_CMD, {5'h0, CMD_WHOLE});
        @(negedge mclk);
        chk({opStart, opEeprom, opCode}, 5'h15, "keep");
        rd(OFS_STATUS, 8'h01, "flash only");
        repeat (210) @(posedge mclk);
        // Erase with an empty buffer does nothing
        kw(1, 0, OFS_CMD, {5'h0, CMD_ERASE});
        @(negedge mclk) chk(opStart, 0, "empty erase");
        rd(OFS_STATUS, 8'h00, "no fault");
        kw(1, 0, OFS_CMD, {5'h0, CMD_NONE});
        rd(OFS_CMD, 8'h00, "none");
        // Loads from two sections fault the page write
        @(posedge mclk) {bufWrite, bufAddr} <= {1'b1, 16'h1400};
        @(posedge mclk) bufAddr <= 16'h8010;
        @(posedge mclk) bufWrite <= 1'b0;
        kw(1, 0, OFS_CMD, {5'h0, CMD_PROG});
        @(negedge mclk) chk(opStart, 0, "mixed op");
        rd(OFS_STATUS, 8'h04, "mixed");
        $display("array erase done");
        // Reset in mid-run releases lock and guard
        @(posedge mclk) srst <= 1'b1;
        repeat (2) @(posedge mclk);
        srst <= 1'b0;
        rd(OFS_LOCK, 8'h00, "reset lock");
        chk(bootHide, 0, "reset hide");
        $display("second reset done");
        summarize();
    end
endmodule : test_nvm_command_controller
`default_nettype wire
